//--- src/adc_compute_pkg.sv
// constants of the adc compute and threshold register block
// assumes apb byte lanes: each byte location takes one word, index*4
package adc_compute_pkg;
	localparam int IX_W = 14;
	// byte-location indices; byte address is index times four
	localparam logic [13:0] IX_LTH_L = 14'h1d0c;
	localparam logic [13:0] IX_LTH_H = 14'h1d0d;
	localparam logic [13:0] IX_UTH_L = 14'h1d0e;
	localparam logic [13:0] IX_UTH_H = 14'h1d0f;
	localparam logic [13:0] IX_ERR_L = 14'h1d10;
	localparam logic [13:0] IX_ERR_H = 14'h1d11;
	localparam logic [13:0] IX_STPT_L = 14'h1d12;
	localparam logic [13:0] IX_STPT_H = 14'h1d13;
	localparam logic [13:0] IX_FLT_L = 14'h1d14;
	localparam logic [13:0] IX_FLT_H = 14'h1d15;
	localparam logic [13:0] IX_ACC_L = 14'h1d16;
	localparam logic [13:0] IX_ACC_M = 14'h1d17;
	localparam logic [13:0] IX_ACC_U = 14'h1d18;
	localparam logic [13:0] IX_PREV_L = 14'h1d1b;
	localparam logic [13:0] IX_PREV_H = 14'h1d1c;
	localparam logic [13:0] IX_RES_L = 14'h1d1d;
	localparam logic [13:0] IX_RES_H = 14'h1d1e;
	localparam logic [13:0] IX_ACT = 14'h1d2c;
	localparam logic [13:0] IX_CTRL = 14'h1d40;
	localparam logic [13:0] IX_CFG = 14'h1d41;
	localparam logic [13:0] IX_STAT = 14'h1d42;
	localparam logic [13:0] IX_MASK = 14'h1d43;
	localparam logic [13:0] IX_TCFG = 14'h1d44;
	// field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_FM = 1;
	localparam int CTRL_PREV_SOURCE_SELECT = 2;
	localparam int CTRL_LOWER_THRESHOLD_FLAG = 4;
	localparam int CTRL_UPPER_THRESHOLD_FLAG = 5;
	localparam int CFG_MODE = 0;
	localparam int CFG_ERROR_MODE_A = 3;
	localparam int TCFG_TMD = 0;
	localparam int TCFG_SHIFT = 4;
	localparam int STAT_DONE = 0;
	localparam int STAT_THR = 1;
	localparam int ACC_W = 18;
	localparam int EVT_W = 2;
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [17:0] RST_ACC = 18'h00000;
	localparam logic [5:0] RST_ACT = 6'h00;
	typedef enum logic [2:0] {
		MODE_BASIC = 3'b000, MODE_ACC = 3'b001, MODE_AVG = 3'b010,
		MODE_BURST = 3'b011, MODE_LPF = 3'b100
	} mode_e;
	typedef enum logic [1:0] {
		ERROR_MODE_A_RES_PREV = 2'b00, ERROR_MODE_A_RES_STPT = 2'b01,
		ERROR_MODE_A_FLT_PREV = 2'b10, ERROR_MODE_A_FLT_STPT = 2'b11
	} error_mode_a_e;
	typedef enum logic [2:0] {
		TMD_NEVER = 3'b000, TMD_BELOW = 3'b001, TMD_NOT_BELOW = 3'b010,
		TMD_OUTSIDE = 3'b011, TMD_INSIDE = 3'b100, TMD_NOT_ABOVE = 3'b101,
		TMD_ABOVE = 3'b110, TMD_ALWAYS = 3'b111
	} tmd_e;
endpackage

//--- src/adc_result_format.sv
// sample formatting and filter output selection, purely combinational
// assumes accumulator and settings are held stable by the caller
`timescale 1ns/1ps
module adc_result_format #(
	parameter int SAMPLE_W = 10
) (
	input wire logic [SAMPLE_W-1:0] sampleRaw,
	input wire logic rightJust,
	input wire logic [2:0] mode,
	input wire logic [17:0] acc,
	input wire logic [2:0] shift,
	input wire logic [15:0] lpfIn,
	output logic [15:0] fmtSample,
	output logic [15:0] filterOut
);
	wire [17:0] accShifted;
	// left or right justified sample
	assign fmtSample = rightJust ? 16'(sampleRaw) : 16'(sampleRaw) << (16 - SAMPLE_W);
	// arithmetic shift keeps the sign of a negative accumulator
	assign accShifted = 18'($signed(acc) >>> shift);
	assign filterOut = (mode == adc_compute_pkg::MODE_LPF) ? lpfIn : accShifted[15:0];
endmodule // adc_result_format

//--- src/adc_threshold_check.sv
// setpoint error against lower and upper thresholds, interrupt mode
// assumes cmpStb is a one-cycle pulse with err already settled
`timescale 1ns/1ps
module adc_threshold_check (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmpStb,
	input wire logic [15:0] err,
	input wire logic [15:0] lowerTh,
	input wire logic [15:0] upperTh,
	input wire logic [2:0] intMode,
	output logic lowerFlag,
	output logic upperFlag,
	output logic thrEvent
);
	logic lowerFlag_r, upperFlag_r, thrEvent_r;
	logic hit;
	wire below = $signed(err) < $signed(lowerTh);
	wire above = $signed(err) > $signed(upperTh);
	always_comb begin
		case (intMode)
			adc_compute_pkg::TMD_NEVER: hit = 1'b0;
			adc_compute_pkg::TMD_BELOW: hit = below;
			adc_compute_pkg::TMD_NOT_BELOW: hit = ~below;
			adc_compute_pkg::TMD_OUTSIDE: hit = below | above;
			adc_compute_pkg::TMD_INSIDE: hit = ~below & ~above;
			adc_compute_pkg::TMD_NOT_ABOVE: hit = ~above;
			adc_compute_pkg::TMD_ABOVE: hit = above;
			default: hit = 1'b1;
		endcase
	end
	// flags only move on a compare
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowerFlag_r <= 1'b0;
			upperFlag_r <= 1'b0;
			thrEvent_r <= 1'b0;
		end else begin
			if (cmpStb) begin
				lowerFlag_r <= below;
				upperFlag_r <= above;
			end
			thrEvent_r <= cmpStb & hit;
		end
	end
	assign lowerFlag = lowerFlag_r;
	assign upperFlag = upperFlag_r;
	assign thrEvent = thrEvent_r;

	property p_lower_flag;
		@(posedge clk) disable iff (!rst_b)
		cmpStb |=> lowerFlag == ($signed($past(err)) < $signed($past(lowerTh)));
	endproperty
	a_lower_flag: assert property (p_lower_flag) else $error("lower flag wrong");
	property p_upper_hold;
		@(posedge clk) disable iff (!rst_b)
		!cmpStb |=> $stable(upperFlag);
	endproperty
	a_upper_hold: assert property (p_upper_hold) else $error("upper flag moved");
	property p_never_int;
		@(posedge clk) disable iff (!rst_b)
		cmpStb && intMode == 3'b000 |=> !thrEvent;
	endproperty
	a_never_int: assert property (p_never_int) else $error("event in never mode");
	property p_above_int;
		@(posedge clk) disable iff (!rst_b)
		cmpStb && intMode == 3'b110 && $signed(err) > $signed(upperTh) |=> thrEvent;
	endproperty
	a_above_int: assert property (p_above_int) else $error("missing above event");
	c_thr_event: cover property (@(posedge clk) disable iff (!rst_b) cmpStb ##1 thrEvent);
endmodule // adc_threshold_check

//--- src/adc_compute_regs.sv
// adc computation and threshold registers behind an apb slave
// assumes convStart/convDone are one-cycle pulses synchronous to clk
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - with source select 1, previous result takes filter output at start.
// - with source select 0, previous result takes the last stored result at start.
// - accumulator is 18-bit signed; bits 23:18 read as sign copies.
// - accumulator writes only land while go is 0.
// - setpoint is 16-bit signed read/write, reset zero, used by error.
// - setpoint error computed per error mode, read-only.
// - error compared with thresholds sets lower and upper flags.
// - threshold interrupt raised only as the interrupt mode selects.
// - lower and upper thresholds are 16-bit signed, reset zero.
// - 6-bit trigger selector, reset zero, bits 7:6 read zero.
// - every multibyte register has separate high and low byte locations.
// - filter output is shifted accumulator, or low-pass output in lpf mode.
module adc_compute_regs #(
	parameter int SAMPLE_W = 10
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic convStart,
	input wire logic convDone,
	input wire logic [SAMPLE_W-1:0] sampleRaw,
	input wire logic [15:0] lpfIn,
	output logic convGo,
	output logic [5:0] triggerSelect,
	output logic irq
);
	logic pready_r, pslverr_r, irq_r;
	logic [31:0] prdata_r;
	logic [15:0] lth_r, uth_r, stpt_r, err_r, prev_r, sample_r;
	logic [17:0] acc_r;
	logic [5:0] act_r;
	logic go_r, fm_r, prev_source_select_r, calcStb_r, cmpStb_r;
	logic [2:0] mode_r, tmd_r, shift_r;
	logic [1:0] error_mode_a_r;
	logic [1:0] stat_r, mask_r;
	logic [7:0] rdByte, ctrlRd;
	logic mapped;
	logic [15:0] fmtSample, filterOut;
	logic lowerFlag, upperFlag, thrEvent;

	// apb phases; a write or read-clear acts only at the completion edge
	wire access = psel & penable;
	wire done = access & pready_r;
	wire [13:0] idx = paddr[15:2];
	wire wrEn = done & pwrite & pstrb[0];
	wire rdEn = done & ~pwrite;
	wire [7:0] wb = pwdata[7:0];

	// write decode, one strobe per byte location
	wire wLthL = wrEn & (idx == adc_compute_pkg::IX_LTH_L);
	wire wLthH = wrEn & (idx == adc_compute_pkg::IX_LTH_H);
	wire wUthL = wrEn & (idx == adc_compute_pkg::IX_UTH_L);
	wire wUthH = wrEn & (idx == adc_compute_pkg::IX_UTH_H);
	wire wStptL = wrEn & (idx == adc_compute_pkg::IX_STPT_L);
	wire wStptH = wrEn & (idx == adc_compute_pkg::IX_STPT_H);
	wire wAct = wrEn & (idx == adc_compute_pkg::IX_ACT);
	wire wCtrl = wrEn & (idx == adc_compute_pkg::IX_CTRL);
	wire wCfg = wrEn & (idx == adc_compute_pkg::IX_CFG);
	wire wMask = wrEn & (idx == adc_compute_pkg::IX_MASK);
	wire wTcfg = wrEn & (idx == adc_compute_pkg::IX_TCFG);
	wire rStat = rdEn & (idx == adc_compute_pkg::IX_STAT);
	// accumulator locked while a conversion runs
	wire accOpen = wrEn & ~go_r;
	wire wAccL = accOpen & (idx == adc_compute_pkg::IX_ACC_L);
	wire wAccM = accOpen & (idx == adc_compute_pkg::IX_ACC_M);
	wire wAccU = accOpen & (idx == adc_compute_pkg::IX_ACC_U);

	wire [15:0] lthNxt = wLthL ? {lth_r[15:8], wb} : wLthH ? {wb, lth_r[7:0]} : lth_r;
	wire [15:0] uthNxt = wUthL ? {uth_r[15:8], wb} : wUthH ? {wb, uth_r[7:0]} : uth_r;
	wire [15:0] stptNxt = wStptL ? {stpt_r[15:8], wb} : wStptH ? {wb, stpt_r[7:0]} : stpt_r;

	// a written byte replaces the running sum
	wire accMode = (mode_r == adc_compute_pkg::MODE_ACC) | (mode_r == adc_compute_pkg::MODE_AVG)
		| (mode_r == adc_compute_pkg::MODE_BURST);
	wire [17:0] accSum = acc_r + 18'(sampleRaw);
	wire [17:0] accNxt = wAccL ? {acc_r[17:8], wb}
		: wAccM ? {acc_r[17:16], wb, acc_r[7:0]}
		: wAccU ? {wb[1:0], acc_r[15:0]}
		: (convDone & accMode) ? accSum : acc_r;
	wire [23:0] accRd = {{6{acc_r[17]}}, acc_r};

	// go: software write beats the hardware clear at conversion end
	wire goNxt = wCtrl ? wb[adc_compute_pkg::CTRL_GO] : (convDone ? 1'b0 : go_r);

	wire [15:0] errNxt = (error_mode_a_r == adc_compute_pkg::ERROR_MODE_A_RES_PREV) ? sample_r - prev_r
		: (error_mode_a_r == adc_compute_pkg::ERROR_MODE_A_RES_STPT) ? sample_r - stpt_r
		: (error_mode_a_r == adc_compute_pkg::ERROR_MODE_A_FLT_PREV) ? filterOut - prev_r
		: filterOut - stpt_r;

	// sticky events: a new event in the read cycle survives the clear
	wire [1:0] evt = {thrEvent, convDone};
	wire [1:0] statNxt = (stat_r & ~{adc_compute_pkg::EVT_W{rStat}}) | evt;
	wire [1:0] maskNxt = wMask ? wb[1:0] : mask_r;

	adc_result_format #(
		.SAMPLE_W(SAMPLE_W)
	) u_fmt (
		.sampleRaw(sampleRaw),
		.rightJust(fm_r),
		.mode(mode_r),
		.acc(acc_r),
		.shift(shift_r),
		.lpfIn(lpfIn),
		.fmtSample(fmtSample),
		.filterOut(filterOut)
	);

	adc_threshold_check u_thr (
		.clk(clk),
		.rst_b(rst_b),
		.cmpStb(cmpStb_r),
		.err(err_r),
		.lowerTh(lth_r),
		.upperTh(uth_r),
		.intMode(tmd_r),
		.lowerFlag(lowerFlag),
		.upperFlag(upperFlag),
		.thrEvent(thrEvent)
	);

	// control byte readback with compare flags
	always_comb begin
		ctrlRd = 8'h00;
		ctrlRd[adc_compute_pkg::CTRL_GO] = go_r;
		ctrlRd[adc_compute_pkg::CTRL_FM] = fm_r;
		ctrlRd[adc_compute_pkg::CTRL_PREV_SOURCE_SELECT] = prev_source_select_r;
		ctrlRd[adc_compute_pkg::CTRL_LOWER_THRESHOLD_FLAG] = lowerFlag;
		ctrlRd[adc_compute_pkg::CTRL_UPPER_THRESHOLD_FLAG] = upperFlag;
	end

	// read mux; unmapped locations answer with an error
	always_comb begin
		rdByte = 8'h00;
		mapped = 1'b1;
		case (idx)
			adc_compute_pkg::IX_LTH_L: rdByte = lth_r[7:0];
			adc_compute_pkg::IX_LTH_H: rdByte = lth_r[15:8];
			adc_compute_pkg::IX_UTH_L: rdByte = uth_r[7:0];
			adc_compute_pkg::IX_UTH_H: rdByte = uth_r[15:8];
			adc_compute_pkg::IX_ERR_L: rdByte = err_r[7:0];
			adc_compute_pkg::IX_ERR_H: rdByte = err_r[15:8];
			adc_compute_pkg::IX_STPT_L: rdByte = stpt_r[7:0];
			adc_compute_pkg::IX_STPT_H: rdByte = stpt_r[15:8];
			adc_compute_pkg::IX_FLT_L: rdByte = filterOut[7:0];
			adc_compute_pkg::IX_FLT_H: rdByte = filterOut[15:8];
			adc_compute_pkg::IX_ACC_L: rdByte = accRd[7:0];
			adc_compute_pkg::IX_ACC_M: rdByte = accRd[15:8];
			adc_compute_pkg::IX_ACC_U: rdByte = accRd[23:16];
			adc_compute_pkg::IX_PREV_L: rdByte = prev_r[7:0];
			adc_compute_pkg::IX_PREV_H: rdByte = prev_r[15:8];
			adc_compute_pkg::IX_RES_L: rdByte = sample_r[7:0];
			adc_compute_pkg::IX_RES_H: rdByte = sample_r[15:8];
			adc_compute_pkg::IX_ACT: rdByte = {2'b00, act_r};
			adc_compute_pkg::IX_CTRL: rdByte = ctrlRd;
			adc_compute_pkg::IX_CFG: rdByte = {3'b000, error_mode_a_r, mode_r};
			adc_compute_pkg::IX_STAT: rdByte = {6'h00, stat_r};
			adc_compute_pkg::IX_MASK: rdByte = {6'h00, mask_r};
			adc_compute_pkg::IX_TCFG: rdByte = {1'b0, shift_r, 1'b0, tmd_r};
			default: mapped = 1'b0;
		endcase
	end

	// apb slave: one wait cycle, data captured on the edge that raises pready
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~mapped;
			if (access & ~pready_r)
				prdata_r <= {24'h000000, rdByte};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lth_r <= adc_compute_pkg::RST_WORD;
			uth_r <= adc_compute_pkg::RST_WORD;
			stpt_r <= adc_compute_pkg::RST_WORD;
			acc_r <= adc_compute_pkg::RST_ACC;
		end else begin
			lth_r <= lthNxt;
			uth_r <= uthNxt;
			stpt_r <= stptNxt;
			acc_r <= accNxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_r <= adc_compute_pkg::RST_ACT;
			go_r <= 1'b0;
			fm_r <= 1'b0;
			prev_source_select_r <= 1'b0;
			mode_r <= adc_compute_pkg::MODE_BASIC;
			error_mode_a_r <= adc_compute_pkg::ERROR_MODE_A_RES_PREV;
			tmd_r <= adc_compute_pkg::TMD_NEVER;
			shift_r <= 3'h0;
		end else begin
			go_r <= goNxt;
			if (wAct)
				act_r <= wb[5:0];
			if (wCtrl) begin
				fm_r <= wb[adc_compute_pkg::CTRL_FM];
				prev_source_select_r <= wb[adc_compute_pkg::CTRL_PREV_SOURCE_SELECT];
			end
			if (wCfg) begin
				mode_r <= wb[adc_compute_pkg::CFG_MODE +: 3];
				error_mode_a_r <= wb[adc_compute_pkg::CFG_ERROR_MODE_A +: 2];
			end
			if (wTcfg) begin
				tmd_r <= wb[adc_compute_pkg::TCFG_TMD +: 3];
				shift_r <= wb[adc_compute_pkg::TCFG_SHIFT +: 3];
			end
		end
	end

	// previous result at start; result, then error, then compare
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= adc_compute_pkg::RST_WORD;
			sample_r <= adc_compute_pkg::RST_WORD;
			err_r <= adc_compute_pkg::RST_WORD;
			calcStb_r <= 1'b0;
			cmpStb_r <= 1'b0;
		end else begin
			if (convStart)
				prev_r <= prev_source_select_r ? filterOut : sample_r;
			if (convDone)
				sample_r <= fmtSample;
			if (calcStb_r)
				err_r <= errNxt;
			calcStb_r <= convDone;
			cmpStb_r <= calcStb_r;
		end
	end

	// status, mask and interrupt line
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= 2'b00;
			mask_r <= 2'b00;
			irq_r <= 1'b0;
		end else begin
			stat_r <= statNxt;
			mask_r <= maskNxt;
			irq_r <= |(statNxt & maskNxt);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign convGo = go_r;
	assign triggerSelect = act_r;
	assign irq = irq_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_prev_filter;
		convStart && prev_source_select_r |=> prev_r == $past(filterOut);
	endproperty
	a_prev_filter: assert property (p_prev_filter) else $error("prev not filter");
	property p_prev_sample;
		convStart && !prev_source_select_r |=> prev_r == $past(sample_r);
	endproperty
	a_prev_sample: assert property (p_prev_sample) else $error("prev not sample");
	property p_acc_sign;
		access && !pready_r && !pwrite && idx == adc_compute_pkg::IX_ACC_U
		|=> prdata_r[7:2] == {6{$past(acc_r[17])}};
	endproperty
	a_acc_sign: assert property (p_acc_sign) else $error("acc sign copy wrong");
	property p_acc_lock;
		wrEn && go_r && !convDone |=> acc_r == $past(acc_r);
	endproperty
	a_acc_lock: assert property (p_acc_lock) else $error("acc written while go");
	property p_stpt_wr;
		wrEn && idx == adc_compute_pkg::IX_STPT_H |=> stpt_r[15:8] == $past(pwdata[7:0]);
	endproperty
	a_stpt_wr: assert property (p_stpt_wr) else $error("setpoint write lost");
	property p_err_error_mode_a;
		calcStb_r && error_mode_a_r == 2'b01 |=> err_r == 16'($past(sample_r) - $past(stpt_r));
	endproperty
	a_err_error_mode_a: assert property (p_err_error_mode_a) else $error("error value wrong");
	property p_lth_byte;
		wrEn && idx == adc_compute_pkg::IX_LTH_L
		|=> lth_r[7:0] == $past(pwdata[7:0]) && lth_r[15:8] == $past(lth_r[15:8]);
	endproperty
	a_lth_byte: assert property (p_lth_byte) else $error("low byte write spilled");
	property p_act_wr;
		wrEn && idx == adc_compute_pkg::IX_ACT |=> act_r == $past(pwdata[5:0]);
	endproperty
	a_act_wr: assert property (p_act_wr) else $error("selector write lost");
	property p_lpf_prev;
		convStart && prev_source_select_r && mode_r == 3'b100 |=> prev_r == $past(lpfIn);
	endproperty
	a_lpf_prev: assert property (p_lpf_prev) else $error("lpf output not used");
	property p_acc_load;
		wrEn && !go_r && idx == adc_compute_pkg::IX_ACC_L |=> acc_r[7:0] == $past(pwdata[7:0]);
	endproperty
	a_acc_load: assert property (p_acc_load) else $error("acc write lost");
	property p_thr_chain;
		convDone |-> ##2 cmpStb_r;
	endproperty
	a_thr_chain: assert property (p_thr_chain) else $error("compare not started");
	c_prev_load: cover property (convStart && prev_source_select_r);
	c_acc_write: cover property (wAccL ##1 convDone);
	c_irq: cover property (rStat && irq_r ##1 !irq_r);
endmodule // adc_compute_regs

//--- tb/adc_compute_regs_tb.sv
// self-checking bench for the adc compute and threshold register block
// assumes one apb slave with a wait state and pulsed conversion inputs
`timescale 1ns/1ps
module adc_compute_regs_tb;
	logic clk;
	logic rst_b;
	logic psel;
	logic penable;
	logic pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic convStart;
	logic convDone;
	logic [9:0] sampleRaw;
	logic [15:0] lpfIn;
	logic convGo;
	logic [5:0] triggerSelect;
	logic irq;
	int nMismatch;
	int checkCount;
	logic [7:0] rdByte;
	logic rdErr;

	adc_compute_regs #(.SAMPLE_W(10)) dut (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .convStart(convStart), .convDone(convDone),
		.sampleRaw(sampleRaw), .lpfIn(lpfIn), .convGo(convGo),
		.triggerSelect(triggerSelect), .irq(irq)
	);

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic complete_run();
		$display("mismatches %0d checks %0d", nMismatch, checkCount);
		if (nMismatch == 0 && checkCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// one transfer; pready, prdata and pslverr taken at the rising edge that completes it
	task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] d,
		input logic [3:0] strb);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		pstrb <= strb;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			nMismatch++;
			$display("[FAIL] %0t no pready", $time);
		end
		rdByte = prdata[7:0];
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// outputs launched by the completion edge settle before callers look
		@(negedge clk);
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 4'h1);
	endtask

	task automatic rd(input logic [13:0] idx, input logic [7:0] exp, input string what);
		apb(1'b0, idx, 8'h00, 4'h1);
		chk_byte(rdByte, exp, what);
	endtask

	// start, then done three cycles later; leaves time for flags and status
	task automatic conv(input logic [9:0] s);
		@(posedge clk);
		convStart <= 1'b1;
		sampleRaw <= s;
		@(posedge clk);
		convStart <= 1'b0;
		repeat (2) @(posedge clk);
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_reset();
		rd(adc_compute_pkg::IX_LTH_L, 8'h00, "lth l");
		rd(adc_compute_pkg::IX_LTH_H, 8'h00, "lth h");
		rd(adc_compute_pkg::IX_UTH_L, 8'h00, "uth l");
		rd(adc_compute_pkg::IX_UTH_H, 8'h00, "uth h");
		rd(adc_compute_pkg::IX_STPT_L, 8'h00, "stpt l");
		rd(adc_compute_pkg::IX_STPT_H, 8'h00, "stpt h");
		rd(adc_compute_pkg::IX_ACT, 8'h00, "act");
		chk_byte({2'b00, triggerSelect}, 8'h00, "trig out");
		chk_bit(irq, 1'b0, "irq rst");
	endtask

	// byte halves written apart must stay apart
	task automatic t_regs();
		wr(adc_compute_pkg::IX_LTH_L, 8'ha5);
		wr(adc_compute_pkg::IX_LTH_H, 8'h5a);
		wr(adc_compute_pkg::IX_UTH_H, 8'hc3);
		wr(adc_compute_pkg::IX_STPT_L, 8'h81);
		wr(adc_compute_pkg::IX_ACT, 8'hff);
		rd(adc_compute_pkg::IX_LTH_L, 8'ha5, "lth l");
		rd(adc_compute_pkg::IX_LTH_H, 8'h5a, "lth h");
		rd(adc_compute_pkg::IX_UTH_L, 8'h00, "uth l");
		rd(adc_compute_pkg::IX_UTH_H, 8'hc3, "uth h");
		rd(adc_compute_pkg::IX_STPT_L, 8'h81, "stpt l");
		rd(adc_compute_pkg::IX_STPT_H, 8'h00, "stpt h");
		rd(adc_compute_pkg::IX_ACT, 8'h3f, "act");
		chk_byte({2'b00, triggerSelect}, 8'h3f, "trig out");
	endtask

	task automatic t_refuse();
		apb(1'b0, 14'h0000, 8'h00, 4'h1);
		chk_bit(rdErr, 1'b1, "unmapped err");
		chk_byte(rdByte, 8'h00, "unmapped data");
		wr(adc_compute_pkg::IX_ERR_L, 8'h77);
		rd(adc_compute_pkg::IX_ERR_L, 8'h00, "err ro");
		chk_bit(rdErr, 1'b0, "mapped err");
		apb(1'b1, adc_compute_pkg::IX_LTH_L, 8'h11, 4'h0);
		rd(adc_compute_pkg::IX_LTH_L, 8'ha5, "no strobe");
	endtask

	task automatic t_acc();
		wr(adc_compute_pkg::IX_ACC_L, 8'h00);
		wr(adc_compute_pkg::IX_ACC_M, 8'h00);
		wr(adc_compute_pkg::IX_ACC_U, 8'h02);
		rd(adc_compute_pkg::IX_ACC_U, 8'hfe, "acc sign");
		wr(adc_compute_pkg::IX_CTRL, 8'h01);
		chk_bit(convGo, 1'b1, "go set");
		wr(adc_compute_pkg::IX_ACC_L, 8'h55);
		rd(adc_compute_pkg::IX_ACC_L, 8'h00, "acc busy");
		conv(10'h000);
		chk_bit(convGo, 1'b0, "go clr");
	endtask

	// accumulate from a written base, then filter and previous-result sources
	task automatic t_filter();
		wr(adc_compute_pkg::IX_CTRL, 8'h02);
		wr(adc_compute_pkg::IX_CFG, 8'h01);
		wr(adc_compute_pkg::IX_ACC_L, 8'h10);
		wr(adc_compute_pkg::IX_ACC_U, 8'h00);
		conv(10'h005);
		rd(adc_compute_pkg::IX_ACC_L, 8'h15, "acc base");
		rd(adc_compute_pkg::IX_ACC_U, 8'h00, "acc pos");
		rd(adc_compute_pkg::IX_FLT_L, 8'h15, "flt");
		conv(10'h003);
		rd(adc_compute_pkg::IX_PREV_L, 8'h05, "prev res");
		rd(adc_compute_pkg::IX_PREV_H, 8'h00, "prev res h");
		wr(adc_compute_pkg::IX_TCFG, 8'h20);
		rd(adc_compute_pkg::IX_FLT_L, 8'h06, "flt shift");
		wr(adc_compute_pkg::IX_CTRL, 8'h06);
		conv(10'h001);
		rd(adc_compute_pkg::IX_PREV_L, 8'h06, "prev flt");
		@(posedge clk);
		lpfIn <= 16'h1234;
		wr(adc_compute_pkg::IX_CFG, 8'h04);
		rd(adc_compute_pkg::IX_FLT_L, 8'h34, "lpf l");
		rd(adc_compute_pkg::IX_FLT_H, 8'h12, "lpf h");
		conv(10'h000);
		rd(adc_compute_pkg::IX_PREV_L, 8'h34, "prev lpf l");
		rd(adc_compute_pkg::IX_PREV_H, 8'h12, "prev lpf h");
	endtask

	// error -11 sits inside lower -16 and upper 0; only some modes fire
	task automatic t_thresh();
		logic [7:0] fire;
		fire = 8'hb4;
		wr(adc_compute_pkg::IX_CTRL, 8'h02);
		wr(adc_compute_pkg::IX_CFG, 8'h08);
		wr(adc_compute_pkg::IX_STPT_L, 8'h10);
		wr(adc_compute_pkg::IX_STPT_H, 8'h00);
		rd(adc_compute_pkg::IX_STPT_L, 8'h10, "stpt base");
		wr(adc_compute_pkg::IX_LTH_L, 8'hf0);
		wr(adc_compute_pkg::IX_LTH_H, 8'hff);
		wr(adc_compute_pkg::IX_UTH_H, 8'h00);
		wr(adc_compute_pkg::IX_MASK, 8'h02);
		for (int m = 0; m < 8; m++) begin
			wr(adc_compute_pkg::IX_TCFG, 8'(m));
			apb(1'b0, adc_compute_pkg::IX_STAT, 8'h00, 4'h1);
			conv(10'h005);
			chk_bit(irq, fire[m], "irq mode");
			rd(adc_compute_pkg::IX_STAT, {6'b0, fire[m], 1'b1}, "stat");
			chk_bit(irq, 1'b0, "irq clr");
		end
		rd(adc_compute_pkg::IX_ERR_L, 8'hf5, "err l");
		rd(adc_compute_pkg::IX_ERR_H, 8'hff, "err h");
		rd(adc_compute_pkg::IX_CTRL, 8'h02, "no flags");
		wr(adc_compute_pkg::IX_LTH_L, 8'h00);
		wr(adc_compute_pkg::IX_LTH_H, 8'h00);
		conv(10'h005);
		rd(adc_compute_pkg::IX_CTRL, 8'h12, "lower flag");
		wr(adc_compute_pkg::IX_LTH_H, 8'h80);
		wr(adc_compute_pkg::IX_UTH_L, 8'hf0);
		wr(adc_compute_pkg::IX_UTH_H, 8'hff);
		wr(adc_compute_pkg::IX_TCFG, 8'h06);
		apb(1'b0, adc_compute_pkg::IX_STAT, 8'h00, 4'h1);
		conv(10'h005);
		rd(adc_compute_pkg::IX_CTRL, 8'h22, "upper flag");
		chk_bit(irq, 1'b1, "irq above");
		wr(adc_compute_pkg::IX_CFG, 8'h00);
		conv(10'h007);
		rd(adc_compute_pkg::IX_ERR_L, 8'h02, "err prev");
	endtask

	// hang guard, far beyond the several hundred cycles the run needs
	initial begin
		#200000;
		nMismatch++;
		$display("[FAIL] %0t watchdog", $time);
		complete_run();
	end

	// reset, then the scenarios in turn
	initial begin
		nMismatch = 0;
		checkCount = 0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		convStart = 1'b0;
		convDone = 1'b0;
		sampleRaw = 10'h000;
		lpfIn = 16'h0000;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_refuse();
		t_acc();
		t_filter();
		t_thresh();
		complete_run();
	end
endmodule // adc_compute_regs_tb
